// ==== logic/exc_gen.v ====
// Servo excitation generator with AHB-Lite register slave
//
// Summary of operation
// [R1] Noise and binary excitation samples update once per gap base-rate ticks.
// [R2] Gap floors at one; tuning normally programs two.
// [R3] Binary mode outputs only plus or minus full amplitude.
// [R4] Controller programs binary sequence depth of nineteen first.
// [R5] Binary sequence period is two to the depth updates.
// [R6] Noise mode outputs pseudo-random value within plus/minus amplitude.
// [R7] Noise/binary run lasts point count times gap base ticks.
// [R8] Transform points and gap apply only to noise and binary.
// [R9] Current injection adds scaled excitation at torque output.
// [R10] Velocity injection drives scaled excitation as velocity command.
// [R11] Max velocity replaces overspeed threshold while active, then restored.
// [R12] Sweep starts at start frequency, above zero, below end.
// [R13] Sweep end frequency at most 8000 Hz, above start.
// [R14] Sweep multiplies frequency by one plus step until past end.
// [R15] Tone mode runs until stop; frequency and amplitude live.
// [R16] Frequency currently applied is readable.
// [R17] 16 kHz single-cycle tick from system clock drives updates.
`timescale 1ns/100ps
`include "exc_gen_defs.vh"
module exc_gen #(
  parameter TICK_DIV = `TICK_DIV,
  parameter AW       = 8
) (
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        RST_B_I,
  // AHB-Lite slave
  input  wire        HSEL_I,
  input  wire [31:0] HADDR_I,
  input  wire [1:0]  HTRANS_I,
  input  wire        HWRITE_I,
  input  wire [2:0]  HSIZE_I,
  input  wire [31:0] HWDATA_I,
  input  wire        HREADY_I,
  output reg  [31:0] HRDATA_O,
  output reg         HREADYOUT_O,
  output reg         HRESP_O,
  // Loop injection
  output reg  [15:0] TORQUE_ADD_O,
  output reg  [15:0] VEL_CMD_O,
  output reg         SAMPLE_STB_O,
  output reg  [31:0] OVERSPEED_O,
  output reg         ACTIVE_O
);
  localparam S_IDLE = 2'd0;
  localparam S_RUN  = 2'd1;
  localparam S_SWP  = 2'd2;

  reg  [1:0]  state_r;
  reg  [31:0] tick_cnt_r;
  reg         tick_r;
  reg  [15:0] gap_r;
  reg  [15:0] gap_cnt_r;
  reg  [4:0]  depth_r;
  reg  [31:0] points_r;
  reg  [15:0] fft_r;
  reg  [15:0] cur_amp_r;
  reg  [15:0] vel_amp_r;
  reg  [31:0] vel_max_r;
  reg  [31:0] overspeed_r;
  reg  [31:0] sine_start_r;
  reg  [31:0] sine_end_r;
  reg  [15:0] sine_step_r;
  reg  [31:0] dwell_r;
  reg  [31:0] tone_freq_r;
  reg         inj_vel_r;
  reg  [1:0]  type_r;
  reg  [31:0] freq_r;
  reg  [31:0] lfsr_r;
  reg  [31:0] seq_cnt_r;
  reg  [31:0] upd_cnt_r;
  reg  [31:0] phase_r;
  reg  [31:0] dwell_cnt_r;
  reg  [15:0] exc_r;
  reg         wr_pend_r;
  reg  [AW-1:0] addr_r;
  wire [15:0] sine_val;
  wire        upd;
  wire        wr_go;
  wire        rd_go;
  wire        start_cmd;
  wire        stop_cmd;
  wire [47:0] step_prod;
  wire [31:0] freq_nxt;
  wire [31:0] freq_up;
  wire [1:0]  cmd_type;
  wire [15:0] amp;

  // Signed scale: excitation (Q1.15) times amplitude, keep product bits 30 to 15
  function [15:0] scale;
    input [15:0] x;
    input [15:0] a;
    reg   [31:0] p;
    begin
      p = $signed(x) * $signed({1'b0, a[14:0]});
      scale = p[30:15];
    end
  endfunction

  assign wr_go = HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
  assign rd_go = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
  assign start_cmd = wr_pend_r & (addr_r == `A_CTRL) &
                     HWDATA_I[`CTRL_START];
  assign stop_cmd  = wr_pend_r & (addr_r == `A_CTRL) &
                     HWDATA_I[`CTRL_STOP];
  assign upd = tick_r & (gap_cnt_r == 16'h0000) & (state_r != S_IDLE); // [R1]
  assign amp = inj_vel_r ? vel_amp_r : cur_amp_r;
  // Percent step in units of 0.01 percent
  assign step_prod = freq_r * ({16'h0000, sine_step_r} + 32'h0000_2710);
  assign freq_nxt  = step_prod[31:0] / 32'h0000_2710; // [R14]
  // Rounding may stall a slow sweep, so force at least one hertz
  assign freq_up   = (freq_nxt == freq_r) ?
                     freq_r + 32'h0000_0001 : freq_nxt;
  // Start and mode share one write: the new mode steers the start
  assign cmd_type  = HWDATA_I[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];

  exc_sine_lut u_sine (
    .phase_i (phase_r[31:24]),
    .sine_o  (sine_val)
  );

  // Base-rate tick
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_DIV - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b1; // [R17]
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // Bus slave: zero-wait, always OKAY
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_pend_r    <= 1'b0;
      addr_r       <= {AW{1'b0}};
      HRDATA_O     <= 32'h0000_0000;
      HREADYOUT_O  <= 1'b1;
      HRESP_O      <= 1'b0;
      gap_r        <= `RST_GAP;
      depth_r      <= `RST_DEPTH;
      points_r     <= `RST_POINTS;
      fft_r        <= `RST_FFT;
      cur_amp_r    <= 16'h0000;
      vel_amp_r    <= 16'h0000;
      vel_max_r    <= 32'h0000_0000;
      overspeed_r  <= 32'h0000_0000;
      sine_start_r <= 32'h0000_0001;
      sine_end_r   <= `SINE_END_MAX;
      sine_step_r  <= 16'h0000;
      dwell_r      <= `RST_DWELL;
      tone_freq_r  <= 32'h0000_0001;
      inj_vel_r    <= 1'b0;
      type_r       <= `TYPE_NOISE;
    end else begin
      wr_pend_r <= wr_go;
      addr_r    <= HADDR_I[AW-1:0];
      if (rd_go) begin
        case (HADDR_I[AW-1:0])
          `A_CTRL:       HRDATA_O <= {27'h0, type_r, inj_vel_r, 2'b00};
          `A_GAP:        HRDATA_O <= {16'h0000, gap_r};
          `A_PRB_DEPTH:  HRDATA_O <= {27'h0, depth_r};
          `A_NUM_POINTS: HRDATA_O <= points_r;
          `A_CUR_AMP:    HRDATA_O <= {16'h0000, cur_amp_r};
          `A_VEL_AMP:    HRDATA_O <= {16'h0000, vel_amp_r};
          `A_VEL_MAX:    HRDATA_O <= vel_max_r;
          `A_OVERSPEED:  HRDATA_O <= overspeed_r;
          `A_SINE_START: HRDATA_O <= sine_start_r;
          `A_SINE_END:   HRDATA_O <= sine_end_r;
          `A_SINE_STEP:  HRDATA_O <= {16'h0000, sine_step_r};
          `A_SINE_FREQ:  HRDATA_O <= freq_r; // [R16]
          `A_STATUS:     HRDATA_O <= {30'h0, state_r};
          `A_DWELL:      HRDATA_O <= dwell_r;
          `A_TONE_FREQ:  HRDATA_O <= tone_freq_r;
          `A_TRANSFORM_POINT_COUNT: HRDATA_O <= {16'h0000, fft_r}; // [R8]
          default:       HRDATA_O <= 32'h0000_0000;
        endcase
      end
      if (wr_pend_r) begin
        case (addr_r)
          `A_CTRL: begin
            // Mode locked while running; amplitude still live
            if (state_r == S_IDLE) begin
              inj_vel_r <= HWDATA_I[`CTRL_INJ_VEL];
              type_r    <= HWDATA_I[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
            end
          end
          // Zero would stall the update divider
          `A_GAP: gap_r <= (HWDATA_I[15:0] == 16'h0000) ?
                           16'h0001 : HWDATA_I[15:0]; // [R2]
          `A_PRB_DEPTH:  depth_r      <= HWDATA_I[4:0]; // [R4]
          `A_NUM_POINTS: points_r     <= HWDATA_I;
          `A_CUR_AMP:    cur_amp_r    <= HWDATA_I[15:0]; // [R15]
          `A_VEL_AMP:    vel_amp_r    <= HWDATA_I[15:0];
          `A_VEL_MAX:    vel_max_r    <= HWDATA_I;
          `A_OVERSPEED:  overspeed_r  <= HWDATA_I;
          `A_SINE_START: sine_start_r <= HWDATA_I; // [R12]
          `A_SINE_END:   sine_end_r   <= HWDATA_I; // [R13]
          `A_SINE_STEP:  sine_step_r  <= HWDATA_I[15:0];
          `A_DWELL:      dwell_r      <= HWDATA_I;
          `A_TONE_FREQ:  tone_freq_r  <= HWDATA_I;
          `A_TRANSFORM_POINT_COUNT: fft_r        <= HWDATA_I[15:0];
          default: ;
        endcase
      end
    end
  end

  // Run control and waveform
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r     <= S_IDLE;
      gap_cnt_r   <= 16'h0000;
      lfsr_r      <= `LFSR_SEED;
      seq_cnt_r   <= 32'h0000_0000;
      upd_cnt_r   <= 32'h0000_0000;
      phase_r     <= 32'h0000_0000;
      dwell_cnt_r <= 32'h0000_0000;
      freq_r      <= 32'h0000_0000;
      exc_r       <= 16'h0000;
    end else begin
      if (tick_r) begin
        gap_cnt_r <= (gap_cnt_r >= gap_r - 16'h0001) ?
                     16'h0000 : gap_cnt_r + 16'h0001; // [R1]
      end
      case (state_r)
        S_IDLE: begin
          exc_r <= 16'h0000;
          if (start_cmd) begin
            gap_cnt_r   <= 16'h0000;
            upd_cnt_r   <= 32'h0000_0000;
            seq_cnt_r   <= 32'h0000_0000;
            lfsr_r      <= `LFSR_SEED;
            phase_r     <= 32'h0000_0000;
            dwell_cnt_r <= 32'h0000_0000;
            freq_r      <= (cmd_type == `TYPE_TONE) ?
                           tone_freq_r : sine_start_r; // [R12]
            state_r     <= (cmd_type == `TYPE_SWEEP) ? S_SWP : S_RUN;
          end
        end
        S_RUN: begin
          if (stop_cmd) begin
            state_r <= S_IDLE;
          end else if (type_r == `TYPE_TONE) begin
            freq_r <= tone_freq_r; // [R15]
            if (tick_r) begin
              phase_r <= phase_r + freq_r * `PHASE_SCALE;
              exc_r   <= sine_val;
            end
          end else if (upd) begin
            lfsr_r <= {lfsr_r[30:0],
                       lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
            // Binary sequence restarts after two to the depth updates
            if (seq_cnt_r == (32'h0000_0001 << depth_r) - 32'h0000_0001) begin
              seq_cnt_r <= 32'h0000_0000;
              lfsr_r    <= `LFSR_SEED; // [R5]
            end else begin
              seq_cnt_r <= seq_cnt_r + 32'h0000_0001;
            end
            if (type_r == `TYPE_PRB)
              exc_r <= lfsr_r[0] ? 16'h7FFF : 16'h8001; // [R3]
            else
              exc_r <= {lfsr_r[15], lfsr_r[14:0]}; // [R6]
            upd_cnt_r <= upd_cnt_r + 32'h0000_0001;
            if (upd_cnt_r == points_r - 32'h0000_0001)
              state_r <= S_IDLE; // [R7]
          end
        end
        S_SWP: begin
          if (stop_cmd || freq_r > sine_end_r) begin
            state_r <= S_IDLE; // [R14]
          end else if (tick_r) begin
            phase_r <= phase_r + freq_r * `PHASE_SCALE;
            exc_r   <= sine_val;
            if (dwell_cnt_r == dwell_r) begin
              dwell_cnt_r <= 32'h0000_0000;
              // A step past the end is never applied nor reported
              if (freq_up > sine_end_r)
                state_r <= S_IDLE; // [R14]
              else
                freq_r  <= freq_up; // [R14]
            end else begin
              dwell_cnt_r <= dwell_cnt_r + 32'h0000_0001;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Injection outputs
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TORQUE_ADD_O <= 16'h0000;
      VEL_CMD_O    <= 16'h0000;
      SAMPLE_STB_O <= 1'b0;
      OVERSPEED_O  <= 32'h0000_0000;
      ACTIVE_O     <= 1'b0;
    end else begin
      ACTIVE_O     <= (state_r != S_IDLE);
      SAMPLE_STB_O <= upd | ((state_r != S_IDLE) & tick_r &
                      (type_r[1] == 1'b1));
      // Threshold swap, restored once idle
      OVERSPEED_O  <= (state_r != S_IDLE) ? vel_max_r : overspeed_r; // [R11]
      // Gated by the lagging flag so the final sample still reaches the loop
      TORQUE_ADD_O <= (ACTIVE_O && !inj_vel_r) ?
                      scale(exc_r, cur_amp_r) : 16'h0000; // [R9]
      VEL_CMD_O    <= (ACTIVE_O && inj_vel_r) ?
                      scale(exc_r, vel_amp_r) : 16'h0000; // [R10]
    end
  end
endmodule // exc_gen

// ==== logic/exc_gen_defs.vh ====
// Register map, field positions and timing constants of the excitation block
`ifndef EXC_GEN_DEFS_VH
`define EXC_GEN_DEFS_VH
`define CLK_HZ          100000000
`define BASE_HZ         16000
`define TICK_DIV        (`CLK_HZ / `BASE_HZ)
`define A_CTRL          8'h00
`define A_GAP           8'h04
`define A_PRB_DEPTH     8'h08
`define A_NUM_POINTS    8'h0C
`define A_CUR_AMP       8'h10
`define A_VEL_AMP       8'h14
`define A_VEL_MAX       8'h18
`define A_OVERSPEED     8'h1C
`define A_SINE_START    8'h20
`define A_SINE_END      8'h24
`define A_SINE_STEP     8'h28
`define A_SINE_FREQ     8'h2C
`define A_STATUS        8'h30
`define A_DWELL         8'h34
`define A_TONE_FREQ     8'h38
`define A_TRANSFORM_POINT_COUNT    8'h3C
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_INJ_VEL    2
`define CTRL_TYPE_LSB   3
`define CTRL_TYPE_MSB   4
`define TYPE_NOISE      2'h0
`define TYPE_PRB        2'h1
`define TYPE_SWEEP      2'h2
`define TYPE_TONE       2'h3
`define RST_GAP         16'h0002
`define RST_DEPTH       5'h13
`define RST_POINTS      32'h0000_4000
`define RST_FFT         16'h1000
`define RST_DWELL       32'h0000_3E80
`define SINE_END_MAX    32'h0000_1F40
`define LFSR_SEED       32'h0000_0001
`define PHASE_SCALE     32'h0004_1893
`endif

// ==== logic/exc_sine_lut.v ====
// Quarter-wave mirrored sine lookup from a phase word
`timescale 1ns/100ps
module exc_sine_lut (
  // Phase in
  input  wire [7:0]  phase_i,
  // Signed sample out
  output reg  [15:0] sine_o
);
  reg [5:0]  idx;
  reg [14:0] mag;
  always @* begin
    idx = phase_i[6] ? ~phase_i[5:0] : phase_i[5:0];
    mag = 15'h0000;
    case (idx[5:3])
      3'd0: mag = 15'h0324;
      3'd1: mag = 15'h1590;
      3'd2: mag = 15'h2AD3;
      3'd3: mag = 15'h3ECD;
      3'd4: mag = 15'h5133;
      3'd5: mag = 15'h6163;
      3'd6: mag = 15'h6D74;
      default: mag = 15'h7DA1;
    endcase
    sine_o = phase_i[7] ? (16'h0000 - {1'b0, mag}) : {1'b0, mag};
  end
endmodule // exc_sine_lut

// ==== sim/exc_gen_asserts.sv ====
// Port-level assertions of the excitation generator
`timescale 1ns/100ps
module exc_gen_asserts #(
  parameter TICK_DIV = 10
) (
  // Clock and reset
  input wire        CLK_SYS_I,
  input wire        RST_B_I,
  // Bus inputs
  input wire        HSEL_I,
  input wire [1:0]  HTRANS_I,
  input wire        HWRITE_I,
  input wire        HREADY_I,
  // Design outputs
  input wire        HREADYOUT_O,
  input wire        HRESP_O,
  input wire [15:0] TORQUE_ADD_O,
  input wire [15:0] VEL_CMD_O,
  input wire        SAMPLE_STB_O,
  input wire [31:0] OVERSPEED_O,
  input wire        ACTIVE_O
);
  reg        wr_r;
  reg [31:0] since_r;
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  // Zero until the first strobe, so start-up never looks too close
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_r    <= 1'b0;
      since_r <= 32'h0000_0000;
    end else begin
      wr_r    <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
      if (SAMPLE_STB_O)
        since_r <= 32'h0000_0001;
      else if (since_r != 32'h0000_0000)
        since_r <= since_r + 32'h0000_0001;
    end
  end
  hready_high_a: assert property (HREADYOUT_O)
    else $error("hreadyout low");
  resp_okay_a: assert property (!HRESP_O)
    else $error("response not okay");
  stb_single_a: assert property
    (SAMPLE_STB_O |=> !SAMPLE_STB_O) else $error("strobe too long");
  stb_spacing_a: assert property
    (SAMPLE_STB_O && since_r != 0 |-> since_r >= TICK_DIV)
    else $error("strobes too close");
  stb_in_run_a: assert property
    (SAMPLE_STB_O |-> ACTIVE_O || $past(ACTIVE_O))
    else $error("strobe while idle");
  inj_excl_a: assert property
    (!(TORQUE_ADD_O != 0 && VEL_CMD_O != 0)) else $error("both injected");
  idle_quiet_a: assert property
    (!ACTIVE_O && !$past(ACTIVE_O) && !$past(ACTIVE_O, 2)
     |-> TORQUE_ADD_O == 0 && VEL_CMD_O == 0) else $error("idle drive");
  fall_quiet_a: assert property
    ($fell(ACTIVE_O) |-> ##[0:2] (TORQUE_ADD_O == 0 && VEL_CMD_O == 0))
    else $error("drive after stop");
  limit_held_a: assert property
    (ACTIVE_O && $past(ACTIVE_O) && $past(ACTIVE_O, 2) && !$past(wr_r)
     && !$past(wr_r, 2) |-> $stable(OVERSPEED_O))
    else $error("threshold moved in run");
endmodule // exc_gen_asserts
bind exc_gen exc_gen_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
  .CLK_SYS_I, .RST_B_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I,
  .HREADYOUT_O, .HRESP_O, .TORQUE_ADD_O, .VEL_CMD_O, .SAMPLE_STB_O,
  .OVERSPEED_O, .ACTIVE_O
);

// ==== sim/servo_loop_model.sv ====
// Loop-side model counting and timing the excitation samples it takes
`timescale 1ns/100ps
module servo_loop_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // From the generator
  input  wire        stb_i,
  input  wire        active_i,
  // Run statistics
  output reg  [15:0] n_stb_o,
  output reg  [15:0] gap_o
);
  reg        act_r;
  reg [15:0] since_r;
  // Count restarts at each run so a stale total never passes
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_r   <= 1'b0;
      n_stb_o <= 16'h0000;
      gap_o   <= 16'h0000;
      since_r <= 16'h0000;
    end else begin
      act_r   <= active_i;
      since_r <= stb_i ? 16'h0001 : since_r + 16'h0001;
      if (stb_i)
        gap_o <= since_r;
      if (active_i && !act_r)
        n_stb_o <= {15'h0000, stb_i};
      else if (stb_i)
        n_stb_o <= n_stb_o + 16'h0001;
    end
  end
endmodule // servo_loop_model

// ==== sim/test_servo_excitation_generator.sv ====
// Self-checking bench of the excitation generator
`timescale 1ns/100ps
`include "exc_gen_defs.vh"
module test_servo_excitation_generator;
  localparam TD = 10;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg  [1:0]  htrans = 2'h0;
  reg  [31:0] haddr = 32'h0000_0000;
  reg  [31:0] hwdata = 32'h0000_0000;
  reg  [31:0] rd;
  reg  [1:0]  mode = 2'h0;
  reg         stb_d = 1'b0;
  wire [31:0] hrdata, ospd;
  wire        hrdy, hresp, stb, active;
  wire [15:0] torque, vel, n_stb, gap;
  integer     num_errors = 0;
  integer     n_compared = 0;
  integer     i, k;
  reg  [31:0] ra [0:8] = '{`A_GAP, `A_PRB_DEPTH, `A_NUM_POINTS,
    `A_SINE_START, `A_SINE_END, `A_DWELL, `A_TRANSFORM_POINT_COUNT, `A_STATUS,
    32'h0000_0040};
  reg  [31:0] re [0:8] = '{`RST_GAP, `RST_DEPTH, `RST_POINTS, 32'h0000_0001,
    `SINE_END_MAX, `RST_DWELL, `RST_FFT, 32'h0000_0000, 32'h0000_0000};
  reg  [31:0] sw [0:2] = '{32'd100, 32'd105, 32'd110};
  always #5 clk = ~clk;
  exc_gen #(.TICK_DIV(TD)) DUT (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .TORQUE_ADD_O(torque),
    .VEL_CMD_O(vel), .SAMPLE_STB_O(stb), .OVERSPEED_O(ospd),
    .ACTIVE_O(active));
  servo_loop_model u_loop (.clk_i(clk), .rst_b_i(rst_b), .stb_i(stb),
    .active_i(active), .n_stb_o(n_stb), .gap_o(gap));
  task final_report;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Bounded wait on the bus answer or on the run flag
  task waitfor(input bus, input v, input integer n);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      while ((bus ? hrdy : active) !== v) begin
        t = t + 1;
        if (t > n) begin
          cmp("wait bound", 32'h0000_0000, 32'h0000_0001);
          final_report;
        end
        @(posedge clk);
      end
    end
  endtask
  task ahb(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      waitfor(1'b1, 1'b1, 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitfor(1'b1, 1'b1, 50);
      rd = hrdata;
    end
  endtask
  // Scaled sample reaches the pins one cycle after its strobe
  always @(posedge clk)
    stb_d <= stb;
  // Level checks on every sample of the noise and binary runs; threshold check in tone runs too
  always @(negedge clk) begin
    if (stb_d === 1'b1 && mode == 2'h1) begin
      cmp("noise bound", 32'h0000_0001, {31'h0, $signed(torque) <= 16'sh3FFF
        && $signed(torque) >= -16'sh4000});
      cmp("noise vel", 32'h0000_0000, {16'h0000, vel});
    end
    if (stb_d === 1'b1 && mode == 2'h2) begin
      cmp("binary level", 32'h0000_0001, {31'h0, vel === 16'h1FFF
        || vel === 16'hE001 || vel === 16'hE000});
      cmp("binary torque", 32'h0000_0000, {16'h0000, torque});
    end
    if (stb === 1'b1 && mode != 2'h0)
      cmp("threshold", 32'h0000_1234, ospd);
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 9; i = i + 1) begin
      ahb(1'b0, ra[i], 32'h0000_0000);
      cmp("reset value", re[i], rd);
    end
    cmp("idle drive", 32'h0000_0000, {ospd[15:0], torque | vel});
    ahb(1'b1, `A_GAP, 32'h0000_0000);
    ahb(1'b0, `A_GAP, 32'h0000_0000);
    cmp("gap floor", 32'h0000_0001, rd);
    ahb(1'b1, `A_NUM_POINTS, 32'h0000_0004);
    ahb(1'b1, `A_CUR_AMP, 32'h0000_4000);
    ahb(1'b1, `A_VEL_MAX, 32'h0000_1234);
    ahb(1'b1, `A_OVERSPEED, 32'h0000_5678);
    mode = 2'h1;
    ahb(1'b1, `A_CTRL, 32'h0000_0001);
    waitfor(1'b0, 1'b1, 50);
    waitfor(1'b0, 1'b0, 200);
    cmp("noise samples", 32'h0000_0004, {16'h0000, n_stb});
    cmp("noise spacing", TD, {16'h0000, gap});
    cmp("restored", 32'h0000_5678, ospd);
    ahb(1'b1, `A_PRB_DEPTH, 32'h0000_0013);
    ahb(1'b1, `A_GAP, 32'h0000_0002);
    ahb(1'b1, `A_NUM_POINTS, 32'h0000_0003);
    ahb(1'b1, `A_VEL_AMP, 32'h0000_2000);
    mode = 2'h2;
    ahb(1'b1, `A_CTRL, 32'h0000_000D);
    waitfor(1'b0, 1'b1, 50);
    waitfor(1'b0, 1'b0, 300);
    cmp("binary samples", 32'h0000_0003, {16'h0000, n_stb});
    cmp("binary spacing", 2 * TD, {16'h0000, gap});
    mode = 2'h0;
    ahb(1'b1, `A_SINE_START, 32'h0000_0064);
    ahb(1'b1, `A_SINE_END, 32'h0000_006E);
    ahb(1'b1, `A_SINE_STEP, 32'h0000_01F4);
    ahb(1'b1, `A_DWELL, 32'h0000_0002);
    ahb(1'b1, `A_CTRL, 32'h0000_0011);
    waitfor(1'b0, 1'b1, 50);
    k = 0;
    rd = 32'h0000_0000;
    for (i = 0; i < 300 && active === 1'b1; i = i + 1) begin
      ahb(1'b0, `A_SINE_FREQ, 32'h0000_0000);
      if (rd !== sw[k - (k > 0)] || k == 0) begin
        cmp("sweep freq", sw[k], rd);
        k = k + 1;
      end
    end
    cmp("sweep steps", 32'h0000_0003, k);
    cmp("sweep ended", 32'h0000_0000, {31'h0, active});
    ahb(1'b1, `A_TONE_FREQ, 32'h0000_0FA0);
    mode = 2'h3;
    ahb(1'b1, `A_CTRL, 32'h0000_0019);
    waitfor(1'b0, 1'b1, 50);
    ahb(1'b1, `A_CTRL, 32'h0000_001C);
    repeat (6 * TD) @(posedge clk);
    cmp("tone on", 32'h0000_0001, {31'h0, active});
    cmp("tone drive", 32'h0000_0001, {31'h0, torque !== 16'h0000});
    cmp("inject locked", 32'h0000_0000, {16'h0000, vel});
    ahb(1'b1, `A_CUR_AMP, 32'h0000_0000);
    repeat (3 * TD) @(posedge clk);
    cmp("live amp", 32'h0000_0000, {16'h0000, torque});
    ahb(1'b1, `A_CTRL, 32'h0000_001A);
    waitfor(1'b0, 1'b0, 50);
    cmp("tone restored", 32'h0000_5678, ospd);
    // Reset in mid-run must drop the run and every drive at once
    mode = 2'h0;
    ahb(1'b1, `A_CTRL, 32'h0000_0019);
    waitfor(1'b0, 1'b1, 50);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("reset run", 32'h0000_0000,
      {ospd[15:0], torque | vel | {15'h0000, active}});
    final_report;
  end
endmodule // test_servo_excitation_generator
